// [asq_partner.sv]
// stand-in for the converter core and the system RAM behind the sequencer
// assumes the sequencer holds each RAM write until it is acknowledged
`timescale 1ns/1ps
`default_nettype none

module asq_partner (
  input wire logic mclk_in,
  input wire logic conv_start_in,
  input wire logic [2:0] conv_ch_in,
  output logic conv_valid_out,
  output logic [asq_pkg::RES_W-1:0] conv_data_out,
  input wire logic mem_req_in,
  input wire asq_pkg::asq_mem_t mem_in,
  output logic mem_ack_out,
  input wire logic slow_in
);
  logic [2:0] lat_q = 3'h0;
  logic [3:0] ack_q = 4'h0;
  logic [asq_pkg::RES_W-1:0] val_q = 12'h000;
  logic [31:0] ram [0:255];

  initial begin
    conv_valid_out = 1'b0;
    mem_ack_out = 1'b0;
    for (int i = 0; i < 256; i++) ram[i] = 32'h0;
  end

  // ----------------------------------------
  // converter core
  // ----------------------------------------
  // negative results on purpose, so sign extension shows in RAM
  always @(posedge mclk_in) begin
    conv_valid_out <= 1'b0;
    if (conv_start_in) begin
      lat_q <= 3'h4;
      val_q <= 12'hf00 + {5'h00, conv_ch_in, 4'h0};
    end else if (lat_q != 3'h0) begin
      lat_q <= lat_q - 3'h1;
      conv_valid_out <= (lat_q == 3'h1);
    end
  end
  // released data lines show the inverse, never a stale result
  assign conv_data_out = conv_valid_out ? val_q : ~val_q;

  // ----------------------------------------
  // RAM with prompt or slow acknowledge
  // ----------------------------------------
  always @(posedge mclk_in) begin
    mem_ack_out <= 1'b0;
    if (mem_req_in && !mem_ack_out) begin
      if (ack_q >= (slow_in ? 4'h6 : 4'h0)) begin
        mem_ack_out <= 1'b1;
        ack_q <= 4'h0;
      end else begin
        ack_q <= ack_q + 4'h1;
      end
    end
    if (mem_req_in && mem_ack_out) begin
      for (int b = 0; b < 4; b++) begin
        if (mem_in.be[b]) ram[mem_in.addr[9:2]][8*b +: 8] <= mem_in.data[8*b +: 8];
      end
    end
  end
endmodule

`default_nettype wire

// [asq_pkg.sv]
// constants, field layouts and carrier types for the converter sequencer
// assumes a 10 MHz system clock and a plain register port with byte offsets
package asq_pkg;

  // ----------------------------------------
  // clock and sizes
  // ----------------------------------------
  localparam int CLK_MHZ = 10;
  localparam int NCH = 8;
  localparam int RES_W = 12;
  localparam int ACC_W = 20;
  localparam int CAP_W = 15;
  localparam int CNT_W = 9;
  localparam logic [3:0] AVG_MAX = 4'h8;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_TASKS = 8'h00;
  localparam logic [7:0] OFF_EVENTS = 8'h04;
  localparam logic [7:0] OFF_POSSEL = 8'h08;
  localparam logic [7:0] OFF_AVG = 8'h0c;
  localparam logic [7:0] OFF_RATE = 8'h10;
  localparam logic [7:0] OFF_PTR = 8'h14;
  localparam logic [7:0] OFF_CAP = 8'h18;
  localparam logic [7:0] OFF_AMOUNT = 8'h1c;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  localparam logic [2:0] CHCFG_PAGE = 3'h2;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int TSK_START = 0;
  localparam int TSK_SAMPLE = 1;
  localparam int TSK_STOP = 2;
  localparam int TSK_CAL = 3;
  localparam int EV_STARTED = 0;
  localparam int EV_END = 1;
  localparam int EV_DONE = 2;
  localparam int EV_RDY = 3;
  localparam int EV_CALD = 4;
  localparam int EV_STOPPED = 5;
  localparam int NEV = 6;
  localparam int CFG_BURST = 4;
  localparam int RATE_MODE = 11;
  localparam int CFG_W = 5;
  localparam int RATE_W = 12;

  // ----------------------------------------
  // acquisition and calibration times
  // ----------------------------------------
  localparam int ACQUISITION_TIME_FIELD_3_US = 3;
  localparam int ACQUISITION_TIME_FIELD_5_US = 5;
  localparam int ACQUISITION_TIME_FIELD_10_US = 10;
  localparam int ACQUISITION_TIME_FIELD_15_US = 15;
  localparam int ACQUISITION_TIME_FIELD_20_US = 20;
  localparam int ACQUISITION_TIME_FIELD_40_US = 40;
  localparam int CAL_US = 20;
  localparam logic [CNT_W-1:0] ACQUISITION_TIME_FIELD_3_CYC = CNT_W'(ACQUISITION_TIME_FIELD_3_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] ACQUISITION_TIME_FIELD_5_CYC = CNT_W'(ACQUISITION_TIME_FIELD_5_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] ACQUISITION_TIME_FIELD_10_CYC = CNT_W'(ACQUISITION_TIME_FIELD_10_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] ACQUISITION_TIME_FIELD_15_CYC = CNT_W'(ACQUISITION_TIME_FIELD_15_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] ACQUISITION_TIME_FIELD_20_CYC = CNT_W'(ACQUISITION_TIME_FIELD_20_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] ACQUISITION_TIME_FIELD_40_CYC = CNT_W'(ACQUISITION_TIME_FIELD_40_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] CAL_CYC = CNT_W'(CAL_US * CLK_MHZ);

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0] be;
  } asq_mem_t;

  typedef struct packed {
    logic stopped;
    logic cal_done;
    logic result_ready;
    logic done;
    logic ended;
    logic started;
  } asq_evt_t;

  typedef enum logic [2:0] {ST_OFF, ST_READY, ST_ACQ, ST_CONV, ST_STORE, ST_CAL} asq_state_t;

endpackage

// [asq_seq.sv]
// sequencer and result writer for a successive-approximation converter
// assumes a converter core answering conv_valid_in, and a RAM port that
// holds a write until it acknowledges; tasks arrive by register or trig_in
//
// Overview of operation
// - one enabled channel: sample task acquires it for its acquisition time
// - done event after each conversion, possibly before the RAM write
// - without averaging, result ready fires with every done
// - rate timer mode: one sample task starts periodic sampling until stop or end
// - averaging collects two to the exponent conversions per stored result, exponent capped at 8
// - burst channel: one sample task runs all averaging conversions back to back
// - with averaging, result ready fires only after the full count
// - positive select enables a channel; several enabled means scan
// - in scan without averaging, or with burst, each sample task converts every enabled channel, ascending
// - two results per 32-bit word; odd capacity leaves a half word last
// - pointer and capacity set before start; start readies the buffer
// - pointer is double-buffered and taken at each start
// - end event when transferred results reach capacity
// - results sign-extended to 16 bits, little-endian
// - stop aborts sampling and always gives stopped
// - RAM writes finish before end or stopped
// - readable count of results written since the last start
// - no sampling after end until a new start
// - acquisition field selects 3 to 40 microseconds
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none

module asq_seq (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  input wire logic [3:0] trig_in,
  output asq_pkg::asq_evt_t evt_out,
  output logic conv_sample_out,
  output logic [2:0] conv_ch_out,
  output logic conv_start_out,
  input wire logic conv_valid_in,
  input wire logic [asq_pkg::RES_W-1:0] conv_data_in,
  output logic mem_req_out,
  output asq_pkg::asq_mem_t mem_out,
  input wire logic mem_ack_in,
  output logic busy_out
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [3:0] next_en(input logic [7:0] mask, input logic [3:0] from);
    logic [3:0] r;
    r = 4'h8;
    for (int i = asq_pkg::NCH - 1; i >= 0; i--) begin
      if (mask[i] && 4'(i) >= from) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [asq_pkg::CNT_W-1:0] acq_cyc(input logic [2:0] code);
    logic [asq_pkg::CNT_W-1:0] r;
    case (code)
      3'h0: r = asq_pkg::ACQUISITION_TIME_FIELD_3_CYC;
      3'h1: r = asq_pkg::ACQUISITION_TIME_FIELD_5_CYC;
      3'h2: r = asq_pkg::ACQUISITION_TIME_FIELD_10_CYC;
      3'h3: r = asq_pkg::ACQUISITION_TIME_FIELD_15_CYC;
      3'h4: r = asq_pkg::ACQUISITION_TIME_FIELD_20_CYC;
      default: r = asq_pkg::ACQUISITION_TIME_FIELD_40_CYC;
    endcase
    return r;
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  localparam asq_pkg::asq_state_t ST_OFF = asq_pkg::ST_OFF, ST_READY = asq_pkg::ST_READY, ST_ACQ = asq_pkg::ST_ACQ;
  localparam asq_pkg::asq_state_t ST_CONV = asq_pkg::ST_CONV, ST_STORE = asq_pkg::ST_STORE, ST_CAL = asq_pkg::ST_CAL;
  asq_pkg::asq_state_t st_q, st_d;
  logic [7:0] pos_sel_q;
  logic [asq_pkg::CFG_W-1:0] chcfg_q [asq_pkg::NCH];
  logic [3:0] avg_q;
  logic [asq_pkg::RATE_W-1:0] rate_q;
  logic [31:0] ptr_q, ptr_act_q;
  logic [asq_pkg::CAP_W-1:0] cap_q, amt_q;
  logic [asq_pkg::NEV-1:0] ev_q, ev_p, ev_pls_q;
  logic [2:0] ch_q, ch_d;
  logic [asq_pkg::CNT_W-1:0] acq_q, ocnt_q;
  logic signed [asq_pkg::ACC_W-1:0] acc_q;
  logic [10:0] tmr_q;
  logic tmr_arm_q, stop_pend_q, conv_start_q, mem_req_q, go_acq, go_cal;
  asq_pkg::asq_mem_t mem_q;
  logic [31:0] rdata_q, rd_mux;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire logic wr_tasks = reg_wr_in && reg_addr_in == asq_pkg::OFF_TASKS;
  wire logic [3:0] tasks = (wr_tasks ? reg_wdata_in[3:0] : 4'h0) | trig_in;
  wire logic start_t = tasks[asq_pkg::TSK_START];
  wire logic sample_t = tasks[asq_pkg::TSK_SAMPLE];
  wire logic stop_t = tasks[asq_pkg::TSK_STOP];
  wire logic cal_t = tasks[asq_pkg::TSK_CAL];
  wire logic cfg_sel = reg_addr_in[7:5] == asq_pkg::CHCFG_PAGE;
  wire logic [2:0] cfg_idx = reg_addr_in[4:2];
  wire logic [3:0] avg_eff = avg_q > asq_pkg::AVG_MAX ? asq_pkg::AVG_MAX : avg_q;
  wire logic [asq_pkg::CNT_W-1:0] n_need = asq_pkg::CNT_W'(1) << avg_eff;
  wire logic avg_full = (ocnt_q + 9'h1) == n_need;
  wire logic [3:0] first_ch = next_en(pos_sel_q, 4'h0);
  wire logic [3:0] next_ch = next_en(pos_sel_q, {1'b0, ch_q} + 4'h1);
  wire logic burst_cur = chcfg_q[ch_q][asq_pkg::CFG_BURST];
  wire logic rate_mode = rate_q[asq_pkg::RATE_MODE];
  wire logic tick = tmr_arm_q && tmr_q >= rate_q[10:0];
  wire logic samp_go = sample_t || tick;
  wire logic [asq_pkg::CAP_W-1:0] amt_nxt = amt_q + 15'h1;
  wire logic last = amt_nxt == cap_q;
  // sign extension of the raw code, kept at accumulator width
  wire logic signed [asq_pkg::ACC_W-1:0] sx = {{(asq_pkg::ACC_W-asq_pkg::RES_W){conv_data_in[asq_pkg::RES_W-1]}},
    conv_data_in};
  wire logic signed [asq_pkg::ACC_W-1:0] acc_sum = acc_q + sx;
  wire logic signed [asq_pkg::ACC_W-1:0] avg_res = acc_sum >>> avg_eff;
  wire logic [31:0] wr_addr = ptr_act_q + {16'h0, amt_q, 1'b0};
  wire logic [3:0] wr_be = amt_q[0] ? 4'hc : 4'h3;
  wire logic [asq_pkg::NEV-1:0] ev_clr = (reg_wr_in && reg_addr_in == asq_pkg::OFF_EVENTS) ?
    reg_wdata_in[asq_pkg::NEV-1:0] : '0;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    ch_d = ch_q;
    go_acq = 1'b0;
    go_cal = 1'b0;
    ev_p = '0;
    unique case (st_q)
      ST_OFF: begin
        // samples after an end are dropped here until a new start
        if (stop_t) begin
          ev_p[asq_pkg::EV_STOPPED] = 1'b1;
        end else if (start_t) begin
          st_d = ST_READY;
          ev_p[asq_pkg::EV_STARTED] = 1'b1;
        end else if (cal_t) begin
          st_d = ST_CAL;
          go_cal = 1'b1;
        end
      end
      ST_READY: begin
        if (stop_t) begin
          st_d = ST_OFF;
          ev_p[asq_pkg::EV_STOPPED] = 1'b1;
        end else if (start_t) begin
          ev_p[asq_pkg::EV_STARTED] = 1'b1;
        end else if (samp_go && !first_ch[3]) begin
          st_d = ST_ACQ;
          ch_d = first_ch[2:0];
          go_acq = 1'b1;
        end
      end
      ST_ACQ: begin
        if (stop_t) begin
          st_d = ST_OFF;
          ev_p[asq_pkg::EV_STOPPED] = 1'b1;
        end else if (acq_q == '0) begin
          st_d = ST_CONV;
        end
      end
      ST_CONV: begin
        if (stop_t) begin
          st_d = ST_OFF;
          ev_p[asq_pkg::EV_STOPPED] = 1'b1;
        end else if (conv_valid_in) begin
          ev_p[asq_pkg::EV_DONE] = 1'b1;
          if (avg_full) begin
            ev_p[asq_pkg::EV_RDY] = 1'b1;
            st_d = ST_STORE;
          end else if (burst_cur) begin
            st_d = ST_ACQ;
            go_acq = 1'b1;
          end else begin
            st_d = ST_READY;
          end
        end
      end
      ST_STORE: begin
        // stop waits for the write in flight so RAM is quiet at the event
        if (mem_ack_in) begin
          if (last) begin
            ev_p[asq_pkg::EV_END] = 1'b1;
            st_d = ST_OFF;
          end
          if (stop_pend_q || stop_t) begin
            ev_p[asq_pkg::EV_STOPPED] = 1'b1;
            st_d = ST_OFF;
          end else if (!last && !next_ch[3]) begin
            st_d = ST_ACQ;
            ch_d = next_ch[2:0];
            go_acq = 1'b1;
          end else if (!last) begin
            st_d = ST_READY;
          end
        end
      end
      ST_CAL: begin
        if (stop_t) begin
          st_d = ST_OFF;
          ev_p[asq_pkg::EV_STOPPED] = 1'b1;
        end else if (acq_q == '0) begin
          ev_p[asq_pkg::EV_CALD] = 1'b1;
          st_d = ST_OFF;
        end
      end
      default: st_d = ST_OFF;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      st_q <= ST_OFF;
      ch_q <= 3'h0;
      acq_q <= '0;
      conv_start_q <= 1'b0;
      stop_pend_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ch_q <= ch_d;
      conv_start_q <= st_q == ST_ACQ && acq_q == '0 && !stop_t;
      stop_pend_q <= st_q == ST_STORE && (stop_pend_q || stop_t) && !mem_ack_in;
      if (go_acq) begin
        acq_q <= acq_cyc(chcfg_q[ch_d][2:0]) - 9'h1;
      end else if (go_cal) begin
        acq_q <= asq_pkg::CAL_CYC - 9'h1;
      end else if (acq_q != '0) begin
        acq_q <= acq_q - 9'h1;
      end
    end
  end

  // ----------------------------------------
  // rate timer
  // ----------------------------------------
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      tmr_arm_q <= 1'b0;
      tmr_q <= 11'h0;
    end else begin
      if (stop_t || st_d == ST_OFF) begin
        tmr_arm_q <= 1'b0;
      end else if (st_q == ST_READY && sample_t && rate_mode) begin
        tmr_arm_q <= 1'b1;
      end
      // a tick during a busy conversion is lost; rate must exceed acq plus conv
      tmr_q <= (tick || !tmr_arm_q) ? 11'h0 : tmr_q + 11'h1;
    end
  end

  // ----------------------------------------
  // accumulator and RAM writer
  // ----------------------------------------
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      acc_q <= '0;
      ocnt_q <= '0;
      mem_req_q <= 1'b0;
      mem_q <= '0;
      amt_q <= '0;
      ptr_act_q <= 32'h0;
    end else begin
      if (ev_p[asq_pkg::EV_STARTED]) begin
        ptr_act_q <= ptr_q;
        amt_q <= '0;
        acc_q <= '0;
        ocnt_q <= '0;
      end else if (st_q == ST_CONV && conv_valid_in && !stop_t) begin
        acc_q <= avg_full ? '0 : acc_sum;
        ocnt_q <= avg_full ? '0 : ocnt_q + 9'h1;
      end else if (st_q == ST_STORE && mem_ack_in) begin
        amt_q <= amt_nxt;
      end
      if (ev_p[asq_pkg::EV_RDY]) begin
        mem_req_q <= 1'b1;
        mem_q.addr <= wr_addr;
        mem_q.data <= {avg_res[15:0], avg_res[15:0]};
        mem_q.be <= wr_be;
      end else if (mem_ack_in) begin
        mem_req_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // registers and event flags
  // ----------------------------------------
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      pos_sel_q <= 8'h0;
      avg_q <= 4'h0;
      rate_q <= '0;
      ptr_q <= 32'h0;
      cap_q <= '0;
      ev_q <= '0;
      ev_pls_q <= '0;
      rdata_q <= 32'h0;
      for (int i = 0; i < asq_pkg::NCH; i++) begin
        chcfg_q[i] <= '0;
      end
    end else begin
      ev_pls_q <= ev_p;
      ev_q <= (ev_q & ~ev_clr) | ev_p;
      rdata_q <= reg_rd_in ? rd_mux : 32'h0;
      if (reg_wr_in) begin
        unique case (reg_addr_in)
          asq_pkg::OFF_POSSEL: pos_sel_q <= reg_wdata_in[7:0];
          asq_pkg::OFF_AVG: avg_q <= reg_wdata_in[3:0];
          asq_pkg::OFF_RATE: rate_q <= reg_wdata_in[asq_pkg::RATE_W-1:0];
          asq_pkg::OFF_PTR: ptr_q <= reg_wdata_in;
          asq_pkg::OFF_CAP: cap_q <= reg_wdata_in[asq_pkg::CAP_W-1:0];
          default: begin
            if (cfg_sel) begin
              chcfg_q[cfg_idx] <= reg_wdata_in[asq_pkg::CFG_W-1:0];
            end
          end
        endcase
      end
    end
  end

  always_comb begin
    rd_mux = 32'h0;
    if (cfg_sel) begin
      rd_mux = {27'h0, chcfg_q[cfg_idx]};
    end else begin
      case (reg_addr_in)
        asq_pkg::OFF_EVENTS: rd_mux = {26'h0, ev_q};
        asq_pkg::OFF_POSSEL: rd_mux = {24'h0, pos_sel_q};
        asq_pkg::OFF_AVG: rd_mux = {28'h0, avg_q};
        asq_pkg::OFF_RATE: rd_mux = {20'h0, rate_q};
        asq_pkg::OFF_PTR: rd_mux = ptr_q;
        asq_pkg::OFF_CAP: rd_mux = {17'h0, cap_q};
        asq_pkg::OFF_AMOUNT: rd_mux = {17'h0, amt_q};
        asq_pkg::OFF_STATUS: rd_mux = {28'h0, tmr_arm_q, st_q};
        default: rd_mux = 32'h0;
      endcase
    end
  end

  assign reg_rdata_out = rdata_q;
  assign evt_out = asq_pkg::asq_evt_t'(ev_pls_q);
  assign conv_sample_out = st_q == ST_ACQ;
  assign conv_ch_out = ch_q;
  assign conv_start_out = conv_start_q;
  assign mem_req_out = mem_req_q;
  assign mem_out = mem_q;
  assign busy_out = st_q != ST_OFF;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (srst_in);

  a_ready_with_done: assert property (ev_p[asq_pkg::EV_DONE] && avg_q == 4'h0 |-> ev_p[asq_pkg::EV_RDY])
    else $error("result ready missing beside done");
  a_done_pulse: assert property (st_q == ST_CONV && conv_valid_in && !stop_t |=> evt_out.done)
    else $error("done not raised after conversion");
  a_avg_count: assert property (ev_p[asq_pkg::EV_RDY] |-> ocnt_q + 9'h1 == n_need)
    else $error("result ready before full average count");
  a_stop_answer: assert property (stop_t && st_q != ST_STORE |=> evt_out.stopped ##1 st_q == ST_OFF)
    else $error("stop not answered");
  a_end_quiet: assert property (ev_p[asq_pkg::EV_END] || ev_p[asq_pkg::EV_STOPPED] |=> !mem_req_out)
    else $error("write still pending at end or stopped");
  a_end_count: assert property (ev_p[asq_pkg::EV_END] |=> amt_q == cap_q)
    else $error("end at wrong count");
  a_acq_load: assert property (go_acq |=> acq_q == acq_cyc(chcfg_q[ch_q][2:0]) - 9'h1)
    else $error("acquisition length wrong");
  a_acq_to_conv: assert property (st_q == ST_ACQ && acq_q == '0 && !stop_t |=> conv_start_out && st_q == ST_CONV)
    else $error("conversion not started after acquisition");
  a_scan_order: assert property (go_acq && st_q == ST_STORE |-> ch_d > ch_q)
    else $error("scan not ascending");
  a_ptr_taken: assert property (ev_p[asq_pkg::EV_STARTED] |=> ptr_act_q == $past(ptr_q) && amt_q == '0)
    else $error("pointer not taken at start");
  a_pack_lane: assert property (ev_p[asq_pkg::EV_RDY] |=> mem_out.be == (amt_q[0] ? 4'hc : 4'h3))
    else $error("wrong half word lane");
  a_burst_repeat: assert property (st_q == ST_CONV && conv_valid_in && !stop_t && !avg_full && burst_cur
    |=> st_q == ST_ACQ)
    else $error("burst did not continue");
  a_no_sample_off: assert property (st_q == ST_OFF |=> st_q != ST_ACQ)
    else $error("sampling without start");
  a_timer_sample: assert property (tick && st_q == ST_READY && !stop_t && !start_t && !first_ch[3]
    |=> st_q == ST_ACQ)
    else $error("timer tick did not sample");

  c_scan_next: cover property (go_acq && st_q == ST_STORE);
  c_burst: cover property (st_q == ST_CONV && conv_valid_in && burst_cur && !avg_full);
  c_end: cover property (evt_out.ended);
  c_stop_in_store: cover property (st_q == ST_STORE && stop_t);

endmodule

`default_nettype wire

// [asq_tb.sv]
// self-checking bench for the converter sequencer
// assumes asq_partner as converter core and RAM, register port as asq_seq declares
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic mclk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [7:0] a_q = 8'h00;
  logic [31:0] wd_q = 32'h0;
  logic wr_q = 1'b0;
  logic rd_q = 1'b0;
  logic [3:0] trig_q = 4'h0;
  logic slow_q = 1'b0;
  logic [31:0] rdata;
  asq_pkg::asq_evt_t evt;
  logic [asq_pkg::NEV-1:0] ev;
  logic smp, cst, cvld, mreq, mack, busy;
  logic [2:0] ch;
  logic [asq_pkg::RES_W-1:0] cdat;
  asq_pkg::asq_mem_t mem;
  int error_cnt = 0;
  int n_tests = 0;
  int cnt [asq_pkg::NEV+1] = '{default: 0};
  int run = 0;
  int last_run = 0;
  int split = 0;
  logic [2:0] chq [$];
  logic [31:0] v;
  int b, w, k, q;
  int acquisition_time_field [8] = '{3, 5, 10, 15, 20, 40, 40, 40};

  always #50 mclk_in = ~mclk_in;
  assign ev = evt;

  asq_seq i_dut (.mclk_in(mclk_in), .srst_in(srst_in), .reg_addr_in(a_q), .reg_wdata_in(wd_q),
    .reg_wr_in(wr_q), .reg_rd_in(rd_q), .reg_rdata_out(rdata), .trig_in(trig_q), .evt_out(evt),
    .conv_sample_out(smp), .conv_ch_out(ch), .conv_start_out(cst), .conv_valid_in(cvld),
    .conv_data_in(cdat), .mem_req_out(mreq), .mem_out(mem), .mem_ack_in(mack), .busy_out(busy));
  asq_partner i_part (.mclk_in(mclk_in), .conv_start_in(cst), .conv_ch_in(ch), .conv_valid_out(cvld),
    .conv_data_out(cdat), .mem_req_in(mreq), .mem_in(mem), .mem_ack_out(mack), .slow_in(slow_q));

  // ----------------------------------------
  // monitor: event pulses, RAM writes, acquisition length
  // ----------------------------------------
  always @(posedge mclk_in) begin
    if (!srst_in) begin
      for (int i = 0; i < asq_pkg::NEV; i++) cnt[i] += (ev[i] === 1'b1) ? 1 : 0;
      cnt[asq_pkg::NEV] += (mreq === 1'b1 && mack === 1'b1) ? 1 : 0;
      split += (evt.done !== evt.result_ready) ? 1 : 0;
      if (cst === 1'b1) chq.push_back(ch);
      if (smp === 1'b1) begin
        run++;
      end else if (run != 0) begin
        last_run = run;
        run = 0;
      end
    end
  end

  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic close_out;
    if (error_cnt == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    a_q <= a;
    wd_q <= d;
    wr_q <= 1'b1;
    @(posedge mclk_in);
    wr_q <= 1'b0;
  endtask

  task automatic chk(input string s, input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk_in);
    a_q <= a;
    rd_q <= 1'b1;
    @(posedge mclk_in);
    rd_q <= 1'b0;
    #1 v = rdata;
    cmp(s, e, v);
  endtask

  task automatic go(input int t);
    wr(asq_pkg::OFF_TASKS, 32'h1 << t);
  endtask

  // bounded wait until a monitor count reaches n
  task automatic wt(input int i, input int n, input int lim);
    k = 0;
    while (cnt[i] < n && k < lim) begin
      @(posedge mclk_in);
      #2;
      k++;
    end
    if (cnt[i] < n) begin
      cmp("wait bound", 32'h1, 32'h0);
      close_out();
    end
  endtask

  task automatic begin_run;
    b = cnt[asq_pkg::EV_STARTED];
    go(asq_pkg::TSK_START);
    wt(asq_pkg::EV_STARTED, b + 1, 10);
    cmp("busy after start", 32'h1, {31'h0, busy});
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge mclk_in);
    srst_in <= 1'b0;
    chk("amount", asq_pkg::OFF_AMOUNT, 32'h0);
    chk("status", asq_pkg::OFF_STATUS, 32'h0);
    chk("unmapped", 8'h3c, 32'h0);
    b = cnt[asq_pkg::EV_STOPPED];
    go(asq_pkg::TSK_STOP);
    wt(asq_pkg::EV_STOPPED, b + 1, 10);
    // one channel, acquisition codes 0 to 6, odd capacity
    wr(asq_pkg::OFF_POSSEL, 32'h1);
    wr(asq_pkg::OFF_PTR, 32'h100);
    wr(asq_pkg::OFF_CAP, 32'h7);
    begin_run();
    wr(asq_pkg::OFF_PTR, 32'h180);
    for (int i = 0; i < 7; i++) begin
      wr(8'h40, 32'(i));
      w = cnt[asq_pkg::NEV];
      go(asq_pkg::TSK_SAMPLE);
      wt(asq_pkg::NEV, w + 1, 600);
      cmp("acq cycles", 32'(acquisition_time_field[i] * asq_pkg::CLK_MHZ), 32'(last_run));
    end
    wt(asq_pkg::EV_END, 1, 10);
    cmp("done count", 32'h7, 32'(cnt[asq_pkg::EV_DONE]));
    cmp("done ready split", 32'h0, 32'(split));
    cmp("word 0", 32'hff00ff00, i_part.ram[8'h40]);
    cmp("last word", 32'h0000ff00, i_part.ram[8'h43]);
    cmp("shadow ptr", 32'h0, i_part.ram[8'h60]);
    chk("amount", asq_pkg::OFF_AMOUNT, 32'h7);
    q = chq.size();
    go(asq_pkg::TSK_SAMPLE);
    repeat (60) @(posedge mclk_in);
    cmp("sample after end", 32'(q), 32'(chq.size()));
    // burst averaging, four conversions for one sample task
    wr(asq_pkg::OFF_AVG, 32'h2);
    wr(8'h40, 32'h1 << asq_pkg::CFG_BURST);
    wr(asq_pkg::OFF_CAP, 32'h1);
    begin_run();
    b = cnt[asq_pkg::EV_DONE];
    w = cnt[asq_pkg::EV_RDY];
    go(asq_pkg::TSK_SAMPLE);
    wt(asq_pkg::EV_END, 2, 1000);
    cmp("burst done", 32'(b + 4), 32'(cnt[asq_pkg::EV_DONE]));
    cmp("burst ready", 32'(w + 1), 32'(cnt[asq_pkg::EV_RDY]));
    cmp("average", 32'h0000ff00, i_part.ram[8'h60]);
    // averaging paced by separate sample tasks, burst off
    wr(8'h40, 32'h0);
    begin_run();
    w = cnt[asq_pkg::EV_RDY];
    for (int i = 0; i < 4; i++) begin
      b = cnt[asq_pkg::EV_DONE];
      go(asq_pkg::TSK_SAMPLE);
      wt(asq_pkg::EV_DONE, b + 1, 100);
    end
    wt(asq_pkg::EV_END, 3, 30);
    cmp("paced ready", 32'(w + 1), 32'(cnt[asq_pkg::EV_RDY]));
    // scan over channels 1, 2 and 5, slow RAM
    wr(asq_pkg::OFF_AVG, 32'h0);
    wr(asq_pkg::OFF_POSSEL, 32'h26);
    wr(asq_pkg::OFF_PTR, 32'h200);
    wr(asq_pkg::OFF_CAP, 32'h3);
    slow_q <= 1'b1;
    q = chq.size();
    begin_run();
    go(asq_pkg::TSK_SAMPLE);
    wt(asq_pkg::EV_END, 4, 600);
    cmp("scan order", {23'h0, 9'o125}, {23'h0, chq[q], chq[q+1], chq[q+2]});
    cmp("scan word 0", 32'hff20ff10, i_part.ram[8'h80]);
    cmp("scan word 1", 32'h0000ff50, i_part.ram[8'h81]);
    // stop from the interconnect in mid acquisition
    wr(asq_pkg::OFF_POSSEL, 32'h1);
    wr(8'h40, 32'h5);
    wr(asq_pkg::OFF_CAP, 32'h4);
    begin_run();
    go(asq_pkg::TSK_SAMPLE);
    repeat (20) @(posedge mclk_in);
    b = cnt[asq_pkg::EV_STOPPED];
    w = cnt[asq_pkg::NEV];
    trig_q <= 4'h4;
    @(posedge mclk_in);
    trig_q <= 4'h0;
    wt(asq_pkg::EV_STOPPED, b + 1, 10);
    cmp("acq after stop", 32'h0, {31'h0, smp});
    cmp("write after stop", 32'(w), 32'(cnt[asq_pkg::NEV]));
    cmp("busy after stop", 32'h0, {31'h0, busy});
    // local rate timer, period of 100 clocks
    wr(8'h40, 32'h0);
    wr(asq_pkg::OFF_RATE, 32'h863);
    wr(asq_pkg::OFF_CAP, 32'h40);
    begin_run();
    w = cnt[asq_pkg::NEV];
    go(asq_pkg::TSK_SAMPLE);
    wt(asq_pkg::NEV, w + 5, 700);
    b = cnt[asq_pkg::EV_STOPPED];
    go(asq_pkg::TSK_STOP);
    wt(asq_pkg::EV_STOPPED, b + 1, 20);
    chk("amount", asq_pkg::OFF_AMOUNT, 32'(cnt[asq_pkg::NEV] - w));
    q = chq.size();
    repeat (250) @(posedge mclk_in);
    cmp("after stop", 32'(q), 32'(chq.size()));
    // sticky event flags and calibration
    chk("events", asq_pkg::OFF_EVENTS, 32'h2f);
    wr(asq_pkg::OFF_EVENTS, 32'h3f);
    b = cnt[asq_pkg::EV_CALD];
    go(asq_pkg::TSK_CAL);
    wt(asq_pkg::EV_CALD, b + 1, 300);
    chk("events", asq_pkg::OFF_EVENTS, 32'h10);
    close_out();
  end
endmodule

`default_nettype wire
